// *** design/srp_rx.sv ***
// srp_rx: receive control, divisors and receive datapath of two serial ports
// assumes: register port on the core clock; link pins asynchronous and slow against i_clk
//
// Contract
// - reset clears both receive control registers
// - bit 0 enables the receiver
// - bits 1-2 select zero, sign, mu, A-law
// - bit 3 selects msb or lsb first
// - bits 4-8 hold word length minus one
// - bit 9 merges two 16-bit words
// - bit 10 selects internal receive clock
// - bit 12 selects rising sampling edge
// - bit 13 requires frame sync per word, except in multichannel mode (bit 23)
// - bit 14 selects internal frame sync, which is generated only while bit 10 is set
// - bit 16 makes frame sync active low
// - bit 17 selects late frame sync timing
// - bits 18, 19 enable dma and chaining
// - bit 21 enables two-dimensional dma
// - bit 22 enables internal loopback
// - bit 23 multichannel, bits 24-28 channels minus one
// - bit 29 sticky overflow until disabled
// - bits 30-31 report buffer fill state
// - disabling clears status; fill may change later
// - divisor registers hold clock, sync divisors; unreset
`timescale 1ns/1ps

module srp_rx (
	input  wire logic                             i_clk,
	input  wire logic                             i_rstn,
	input  wire logic                             i_reg_wr,
	input  wire logic                             i_reg_rd,
	input  wire logic [7:0]                       i_reg_addr,
	input  wire logic [31:0]                      i_reg_wdata,
	output logic      [31:0]                      o_reg_rdata,
	output logic                                  o_reg_rvalid,
	input  wire srp_pkg::srp_link_in_t [1:0]      i_link,
	input  wire logic [1:0]                       i_loop_data,
	output srp_pkg::srp_link_out_t [1:0]          o_link,
	input  wire logic [1:0]                       i_rx_pop,
	output logic      [1:0][31:0]                 o_rx_data,
	output logic      [1:0]                       o_dma_req,
	output logic      [1:0]                       o_dma_chain,
	output logic      [1:0]                       o_dma_2d
);

	typedef struct packed {
		logic [31:0]            ctl;
		srp_pkg::srp_link_in_t  s1;
		srp_pkg::srp_link_in_t  s2;
		logic                   clk_prev;
		logic                   active;
		logic                   started;
		logic [4:0]             bitcnt;
		logic [4:0]             chcnt;
		logic [31:0]            sh;
		logic                   half_pend;
		logic [15:0]            half;
		logic [1:0][31:0]       buf_word;
		logic [1:0]             cnt;
		logic                   ovf;
		logic                   dreq;
	} srp_port_t;

	typedef struct packed {
		srp_port_t [1:0]        p;
		logic [31:0]            rdata;
		logic                   rvalid;
	} srp_state_t;

	typedef struct packed {
		logic [1:0][31:0]       tx_div;
		logic [1:0][31:0]       rx_div;
	} srp_div_t;

	srp_state_t s_reg;
	srp_state_t s_next;
	srp_div_t   d_reg;
	srp_pkg::srp_link_out_t [1:0] gen_link;

	function automatic logic [31:0] srp_shift(input logic [31:0] sh, input logic lsb,
			input logic d);
		return lsb ? {d, sh[31:1]} : {sh[30:0], d};
	endfunction

	function automatic logic [31:0] srp_expand(input logic [7:0] c, input logic alaw);
		logic [7:0]  x;
		logic [15:0] mag;
		logic        neg;
		x = alaw ? (c ^ srp_pkg::SRP_A_LAW_XOR) : ~c;
		if (alaw) begin
			if (x[6:4] == 3'h0) begin
				mag = {8'h00, x[3:0], 4'h8};
			end else begin
				mag = 16'({7'h00, 1'b1, x[3:0], 4'h8} << 3'(x[6:4] - 3'h1));
			end
			neg = ~x[7];
		end else begin
			mag = 16'(({8'h00, 1'b1, x[3:0], 3'h4} << x[6:4]) - srp_pkg::SRP_MU_BIAS);
			neg = x[7];
		end
		return neg ? 32'(-{16'h0000, mag}) : {16'h0000, mag};
	endfunction

	// right-justify the assembled bits and apply the selected format
	function automatic logic [31:0] srp_format(input logic [31:0] sh, input logic [4:0] len,
			input logic lsb, input logic [1:0] fmt);
		logic [31:0] mask;
		logic [31:0] v;
		mask = ~(32'hffff_fffe << len);
		v = lsb ? (sh >> (5'h1f - len)) : (sh & mask);
		case (fmt)
			srp_pkg::SRP_FMT_ZERO_FILL: v = v & mask;
			srp_pkg::SRP_FMT_SIGN_EXT: v = v[len] ? (v | ~mask) : (v & mask);
			srp_pkg::SRP_FMT_MU_LAW: v = srp_expand(v[7:0], 1'b0);
			srp_pkg::SRP_FMT_A_LAW: v = srp_expand(v[7:0], 1'b1);
			default: v = v & mask;
		endcase
		return v;
	endfunction

	function automatic logic [1:0] srp_fill(input logic [1:0] cnt);
		case (cnt)
			2'h0: return srp_pkg::SRP_FILL_EMPTY;
			2'h1: return srp_pkg::SRP_FILL_PART;
			default: return srp_pkg::SRP_FILL_FULL;
		endcase
	endfunction

	genvar gi;
	generate
		for (gi = 0; gi < srp_pkg::SRP_PORTS; gi++) begin : g_div
			srp_rxdiv u_div (
				.i_clk       (i_clk),
				.i_rstn      (i_rstn),
				.i_clk_en    (s_reg.p[gi].ctl[srp_pkg::SRP_B_INT_CLOCK]),
				.i_fs_en     (s_reg.p[gi].ctl[srp_pkg::SRP_B_INT_FS]),
				.i_clock_div (d_reg.rx_div[gi][srp_pkg::SRP_B_CLOCK_DIV +: 16]),
				.i_sync_div  (d_reg.rx_div[gi][srp_pkg::SRP_B_SYNC_DIV +: 16]),
				.o_link      (gen_link[gi])
			);
		end
	endgenerate

	always_comb begin
		logic [31:0] c;
		logic        en;
		logic        sel_clk;
		logic        edge_s;
		logic        fs_act;
		logic        din;
		logic        start_ok;
		logic        take;
		logic        done;
		logic        push;
		logic [31:0] w;
		c = 32'h0000_0000;
		en = 1'b0;
		sel_clk = 1'b0;
		edge_s = 1'b0;
		fs_act = 1'b0;
		din = 1'b0;
		start_ok = 1'b0;
		take = 1'b0;
		done = 1'b0;
		push = 1'b0;
		w = 32'h0000_0000;
		s_next = s_reg;
		s_next.rvalid = i_reg_rd;
		for (int i = 0; i < srp_pkg::SRP_PORTS; i++) begin
			c = s_reg.p[i].ctl;
			en = c[srp_pkg::SRP_B_PORT_ENABLE];
			s_next.p[i].s1 = i_link[i];
			s_next.p[i].s2 = s_reg.p[i].s1;
			sel_clk = c[srp_pkg::SRP_B_INT_CLOCK] ? gen_link[i].sclk
				: s_reg.p[i].s2.sclk;
			s_next.p[i].clk_prev = sel_clk;
			edge_s = c[srp_pkg::SRP_B_SAMPLE_EDGE] ? (sel_clk & ~s_reg.p[i].clk_prev)
				: (~sel_clk & s_reg.p[i].clk_prev);
			fs_act = (c[srp_pkg::SRP_B_INT_FS] ? gen_link[i].fs : s_reg.p[i].s2.fs)
				^ c[srp_pkg::SRP_B_FS_POLARITY];
			din = c[srp_pkg::SRP_B_LOOPBACK] ? i_loop_data[i] : s_reg.p[i].s2.dat;
			start_ok = fs_act || (s_reg.p[i].started && (c[srp_pkg::SRP_B_MULTICHANNEL]
				|| !c[srp_pkg::SRP_B_FS_REQUIRED]));
			take = 1'b0;
			done = 1'b0;
			push = 1'b0;
			if (i_rx_pop[i] && s_reg.p[i].cnt != 2'h0) begin
				s_next.p[i].buf_word[0] = s_reg.p[i].buf_word[1];
				s_next.p[i].cnt = 2'(s_reg.p[i].cnt - 2'h1);
			end
			if (en && edge_s) begin
				if (!s_reg.p[i].active && start_ok) begin
					s_next.p[i].started = 1'b1;
					s_next.p[i].active = 1'b1;
					s_next.p[i].bitcnt = 5'h00;
					// late sync marks the first bit itself
					take = c[srp_pkg::SRP_B_LATE_FS];
				end else begin
					take = s_reg.p[i].active;
				end
			end
			if (take) begin
				s_next.p[i].sh = srp_shift(s_reg.p[i].sh, c[srp_pkg::SRP_B_BIT_ORDER], din);
				if (s_next.p[i].bitcnt == c[srp_pkg::SRP_B_WORD_LEN +: 5]) begin
					done = 1'b1;
					s_next.p[i].active = 1'b0;
				end else begin
					s_next.p[i].bitcnt = 5'(s_next.p[i].bitcnt + 5'h01);
				end
			end
			if (done) begin
				w = srp_format(s_next.p[i].sh, c[srp_pkg::SRP_B_WORD_LEN +: 5],
					c[srp_pkg::SRP_B_BIT_ORDER], c[srp_pkg::SRP_B_FORMAT +: 2]);
				if (c[srp_pkg::SRP_B_MULTICHANNEL]) begin
					if (s_reg.p[i].chcnt == c[srp_pkg::SRP_B_CHANNELS +: 5]) begin
						s_next.p[i].chcnt = 5'h00;
						s_next.p[i].started = 1'b0;
					end else begin
						s_next.p[i].chcnt = 5'(s_reg.p[i].chcnt + 5'h01);
					end
				end
				if (c[srp_pkg::SRP_B_HALFWORD_MERGE] && !s_reg.p[i].half_pend) begin
					s_next.p[i].half = w[15:0];
					s_next.p[i].half_pend = 1'b1;
				end else begin
					if (c[srp_pkg::SRP_B_HALFWORD_MERGE]) begin
						w = {w[15:0], s_reg.p[i].half};
					end
					s_next.p[i].half_pend = 1'b0;
					push = 1'b1;
				end
			end
			if (push) begin
				if (s_next.p[i].cnt == srp_pkg::SRP_BUF_DEPTH) begin
					s_next.p[i].ovf = 1'b1;
				end else begin
					s_next.p[i].buf_word[s_next.p[i].cnt[0]] = w;
					s_next.p[i].cnt = 2'(s_next.p[i].cnt + 2'h1);
				end
			end
			if (!en) begin
				// status held clear while disabled, fill still follows pops
				s_next.p[i].active = 1'b0;
				s_next.p[i].started = 1'b0;
				s_next.p[i].chcnt = 5'h00;
				s_next.p[i].half_pend = 1'b0;
				s_next.p[i].ovf = 1'b0;
			end
			if (i_reg_wr && i_reg_addr == srp_pkg::SRP_OFF_RX_CONTROL[i]) begin
				s_next.p[i].ctl = i_reg_wdata & srp_pkg::SRP_CTL_WMASK;
				if (!i_reg_wdata[srp_pkg::SRP_B_PORT_ENABLE]) begin
					s_next.p[i].cnt = 2'h0;
					s_next.p[i].ovf = 1'b0;
				end
			end
			s_next.p[i].dreq = s_next.p[i].ctl[srp_pkg::SRP_B_DMA_ENABLE]
				&& s_next.p[i].ctl[srp_pkg::SRP_B_PORT_ENABLE]
				&& s_next.p[i].cnt != 2'h0;
		end
		if (i_reg_rd) begin
			s_next.rdata = srp_pkg::SRP_RDATA_NONE;
			for (int i = 0; i < srp_pkg::SRP_PORTS; i++) begin
				if (i_reg_addr == srp_pkg::SRP_OFF_RX_CONTROL[i]) begin
					s_next.rdata = s_reg.p[i].ctl;
					s_next.rdata[srp_pkg::SRP_B_OVERFLOW] = s_reg.p[i].ovf;
					s_next.rdata[srp_pkg::SRP_B_FILL +: 2] = srp_fill(s_reg.p[i].cnt);
				end
				if (i_reg_addr == srp_pkg::SRP_OFF_TX_DIVISOR[i]) begin
					s_next.rdata = d_reg.tx_div[i];
				end
				if (i_reg_addr == srp_pkg::SRP_OFF_RX_DIVISOR[i]) begin
					s_next.rdata = d_reg.rx_div[i];
				end
			end
		end
	end

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			s_reg <= '0;
			for (int i = 0; i < srp_pkg::SRP_PORTS; i++) begin
				s_reg.p[i].ctl <= srp_pkg::SRP_CTL_RESET;
			end
		end else begin
			s_reg <= s_next;
		end
	end

	// divisors keep whatever they power up with
	always_ff @(posedge i_clk) begin
		for (int i = 0; i < srp_pkg::SRP_PORTS; i++) begin
			if (i_reg_wr && i_reg_addr == srp_pkg::SRP_OFF_TX_DIVISOR[i]) begin
				d_reg.tx_div[i] <= i_reg_wdata;
			end
			if (i_reg_wr && i_reg_addr == srp_pkg::SRP_OFF_RX_DIVISOR[i]) begin
				d_reg.rx_div[i] <= i_reg_wdata;
			end
		end
	end

	assign o_reg_rdata = s_reg.rdata;
	assign o_reg_rvalid = s_reg.rvalid;
	assign o_link = gen_link;

	generate
		for (gi = 0; gi < srp_pkg::SRP_PORTS; gi++) begin : g_out
			assign o_rx_data[gi] = s_reg.p[gi].buf_word[0];
			assign o_dma_req[gi] = s_reg.p[gi].dreq;
			assign o_dma_chain[gi] = s_reg.p[gi].ctl[srp_pkg::SRP_B_DMA_CHAIN];
			assign o_dma_2d[gi] = s_reg.p[gi].ctl[srp_pkg::SRP_B_TWO_DIM_DMA];
		end
	endgenerate

endmodule

// *** design/srp_pkg.sv ***
// srp_pkg: constants, field positions and carrier types of the serial receive control block
// assumes: a single core clock; register addresses are the word addresses of the core's bus
package srp_pkg;

	localparam int SRP_PORTS = 2;

	// register addresses, index 0 is serial port 0, index 1 is serial port 1
	localparam logic [1:0][7:0] SRP_OFF_RX_CONTROL = {8'hf1, 8'he1};
	localparam logic [1:0][7:0] SRP_OFF_TX_DIVISOR = {8'hf4, 8'he4};
	localparam logic [1:0][7:0] SRP_OFF_RX_DIVISOR = {8'hf6, 8'he6};

	localparam logic [31:0] SRP_CTL_RESET = 32'h0000_0000;
	// writable control bits: reserved 11, 15, 20 and status 29-31 excluded
	localparam logic [31:0] SRP_CTL_WMASK = 32'h1fef_77ff;
	localparam logic [31:0] SRP_RDATA_NONE = 32'h0000_0000;

	// control field positions
	localparam int SRP_B_PORT_ENABLE = 0;
	localparam int SRP_B_FORMAT = 1;
	localparam int SRP_B_BIT_ORDER = 3;
	localparam int SRP_B_WORD_LEN = 4;
	localparam int SRP_B_HALFWORD_MERGE = 9;
	localparam int SRP_B_INT_CLOCK = 10;
	localparam int SRP_B_SAMPLE_EDGE = 12;
	localparam int SRP_B_FS_REQUIRED = 13;
	localparam int SRP_B_INT_FS = 14;
	localparam int SRP_B_FS_POLARITY = 16;
	localparam int SRP_B_LATE_FS = 17;
	localparam int SRP_B_DMA_ENABLE = 18;
	localparam int SRP_B_DMA_CHAIN = 19;
	localparam int SRP_B_TWO_DIM_DMA = 21;
	localparam int SRP_B_LOOPBACK = 22;
	localparam int SRP_B_MULTICHANNEL = 23;
	localparam int SRP_B_CHANNELS = 24;
	localparam int SRP_B_OVERFLOW = 29;
	localparam int SRP_B_FILL = 30;

	// divisor field positions
	localparam int SRP_B_CLOCK_DIV = 0;
	localparam int SRP_B_SYNC_DIV = 16;

	// format select encodings
	localparam logic [1:0] SRP_FMT_ZERO_FILL = 2'h0;
	localparam logic [1:0] SRP_FMT_SIGN_EXT = 2'h1;
	localparam logic [1:0] SRP_FMT_MU_LAW = 2'h2;
	localparam logic [1:0] SRP_FMT_A_LAW = 2'h3;

	// buffer fill encodings and buffer depth
	localparam logic [1:0] SRP_FILL_EMPTY = 2'h0;
	localparam logic [1:0] SRP_FILL_PART = 2'h2;
	localparam logic [1:0] SRP_FILL_FULL = 2'h3;
	localparam logic [1:0] SRP_BUF_DEPTH = 2'h2;

	// companding constants
	localparam logic [7:0] SRP_A_LAW_XOR = 8'h55;
	localparam logic [15:0] SRP_MU_BIAS = 16'h0084;

	typedef struct packed {
		logic sclk;
		logic fs;
		logic dat;
	} srp_link_in_t;

	typedef struct packed {
		logic sclk;
		logic sclk_oe;
		logic fs;
		logic fs_oe;
	} srp_link_out_t;

endpackage

// *** design/srp_rxdiv.sv ***
// srp_rxdiv: internal receive clock and frame sync generator for one serial port
// assumes: divisors are stable while enabled; fs changes only as the clock falls
`timescale 1ns/1ps

module srp_rxdiv (
	input  wire logic                  i_clk,
	input  wire logic                  i_rstn,
	input  wire logic                  i_clk_en,
	input  wire logic                  i_fs_en,
	input  wire logic [15:0]           i_clock_div,
	input  wire logic [15:0]           i_sync_div,
	output srp_pkg::srp_link_out_t     o_link
);

	typedef struct packed {
		logic [15:0]           cnt;
		logic [15:0]           fscnt;
		srp_pkg::srp_link_out_t out;
	} srp_div_state_t;

	srp_div_state_t s_reg;
	srp_div_state_t s_next;

	always_comb begin
		s_next = s_reg;
		s_next.out.sclk_oe = i_clk_en;
		s_next.out.fs_oe = i_fs_en;
		if (!i_clk_en) begin
			s_next.cnt = 16'h0000;
			s_next.fscnt = 16'h0000;
			s_next.out.sclk = 1'b0;
			s_next.out.fs = 1'b0;
		end else if (s_reg.cnt == i_clock_div) begin
			// half period is divisor plus one core cycles
			s_next.cnt = 16'h0000;
			s_next.out.sclk = ~s_reg.out.sclk;
			if (s_reg.out.sclk) begin
				if (s_reg.fscnt == i_sync_div) begin
					s_next.fscnt = 16'h0000;
					s_next.out.fs = i_fs_en;
				end else begin
					s_next.fscnt = 16'(s_reg.fscnt + 16'h0001);
					s_next.out.fs = 1'b0;
				end
			end
		end else begin
			s_next.cnt = 16'(s_reg.cnt + 16'h0001);
		end
	end

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	assign o_link = s_reg.out;

endmodule

// *** sim/srp_rx_properties.sv ***
// srp_rx_properties: port-level assertions for srp_rx
// assumes: bound to srp_rx; writes to one control register at least four cycles apart
`timescale 1ns/1ps

module srp_rx_properties (
	input wire logic			i_clk,
	input wire logic			i_rstn,
	input wire logic			i_reg_wr,
	input wire logic			i_reg_rd,
	input wire logic [7:0]			i_reg_addr,
	input wire logic [31:0]			i_reg_wdata,
	input wire logic [31:0]			o_reg_rdata,
	input wire logic			o_reg_rvalid,
	input wire srp_pkg::srp_link_out_t [1:0]	o_link,
	input wire logic [1:0]			o_dma_req,
	input wire logic [1:0]			o_dma_chain,
	input wire logic [1:0]			o_dma_2d
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rstn);
	logic	mapped;
	assign mapped = i_reg_addr inside {8'he1, 8'he4, 8'he6, 8'hf1, 8'hf4, 8'hf6};

	property div_back;
		logic [31:0] d;
		(i_reg_wr && i_reg_addr == 8'he6, d = i_reg_wdata) ##[1:8]
			(i_reg_rd && i_reg_addr == 8'he6) |=> o_reg_rdata == d;
	endproperty
	property ctl_bit(logic [7:0] a, int b, logic o);
		logic v;
		(i_reg_wr && i_reg_addr == a, v = i_reg_wdata[b]) |-> ##3 o == v;
	endproperty

	read_answers_a: assert property (i_reg_rd |=> o_reg_rvalid)
		else $error("read not answered");
	answer_caused_a: assert property (o_reg_rvalid |-> $past(i_reg_rd))
		else $error("answer without read");
	unmapped_zero_a: assert property (i_reg_rd && !mapped |=> o_reg_rdata == 32'h0000_0000)
		else $error("unmapped read not zero");
	rdata_holds_a: assert property (!o_reg_rvalid |-> $stable(o_reg_rdata))
		else $error("read data moved");
	div_readback_a: assert property (div_back)
		else $error("divisor readback wrong");
	dma_chain_a: assert property (ctl_bit(8'he1, 19, o_dma_chain[0]))
		else $error("chain level wrong");
	dma_two_dim_a: assert property (ctl_bit(8'hf1, 21, o_dma_2d[1]))
		else $error("2d level wrong");
	dma_off_a: assert property (i_reg_wr && i_reg_addr == 8'he1 && !i_reg_wdata[0]
		|-> ##3 !o_dma_req[0])
		else $error("dma request while disabled");
	idle_link_a: assert property (!o_link[0].sclk_oe |-> !o_link[0].sclk && !o_link[0].fs)
		else $error("internal clock moves while not driven");

	cover property (o_reg_rvalid && o_reg_rdata[31:29] == 3'h7);
	cover property (o_dma_req[0]);
	cover property (o_link[0].sclk_oe);
endmodule

// *** sim/srp_peer.sv ***
// srp_peer: behavioural external serial transmitter for one receive port
// assumes: mode() is called while the port is disabled
`timescale 1ns/1ps

module srp_peer (
	output srp_pkg::srp_link_in_t o_link
);
	logic ck = 1'b0;
	logic inv = 1'b0;
	logic low = 1'b0;
	logic fs = 1'b0;
	logic d = 1'b0;

	// clock stands still between frames; inversion moves the sample edge
	assign o_link = {ck ^ inv, fs ^ low, d};

	task automatic mode(input logic lo, input logic fa);
		// pin changes kept off the core clock edge
		#10;
		low = lo;
		inv = fa;
	endtask

	task automatic send(input logic [31:0] w, input int n, input logic late);
		#10;
		fs = 1'b1;
		if (!late) begin
			#400;
			ck = 1'b1;
			#400;
			ck = 1'b0;
			fs = 1'b0;
		end
		for (int i = n - 1; i >= 0; i--) begin
			d = w[i];
			#400;
			ck = 1'b1;
			#400;
			ck = 1'b0;
			fs = 1'b0;
		end
		// released line shows the inverse of the last bit
		d = ~d;
		#400;
	endtask
endmodule

// *** sim/tb_srp_rx.sv ***
// tb_srp_rx: self-checking bench for srp_rx, peer model on port 0
// assumes: 10 MHz core clock; port 1 pins idle, port 1 uses its internal divider
`timescale 1ns/1ps

module tb_srp_rx;
	logic				clk = 1'b0;
	logic				rstn = 1'b0;
	logic				wr = 1'b0;
	logic				rd = 1'b0;
	logic [7:0]			addr = 8'h00;
	logic [31:0]			wdata = 32'h0000_0000;
	logic [1:0]			loop = 2'b00;
	logic [1:0]			pop = 2'b00;
	logic [31:0]			rdata;
	logic				rvalid;
	logic [1:0]			dreq;
	logic [1:0]			dchn;
	logic [1:0]			d2d;
	logic [1:0][31:0]		rxd;
	srp_pkg::srp_link_out_t [1:0]	lko;
	srp_pkg::srp_link_in_t		lk0;
	int				bad_count = 0;
	int				checks_done = 0;

	always #50 clk = ~clk;

	srp_rx u_dut (.i_clk(clk), .i_rstn(rstn), .i_reg_wr(wr), .i_reg_rd(rd),
		.i_reg_addr(addr), .i_reg_wdata(wdata), .o_reg_rdata(rdata),
		.o_reg_rvalid(rvalid), .i_link({3'b000, lk0}), .i_loop_data(loop),
		.o_link(lko), .i_rx_pop(pop), .o_rx_data(rxd), .o_dma_req(dreq),
		.o_dma_chain(dchn), .o_dma_2d(d2d));
	srp_peer u_peer (.o_link(lk0));

	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= v;
		@(posedge clk);
		wr <= 1'b0;
		repeat (3) @(posedge clk);
	endtask

	task automatic rd_chk(input string n, input logic [7:0] a, input logic [31:0] e);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		chk(n, e, (rvalid === 1'b1) ? rdata : 32'hxxxx_xxxx);
	endtask

	task automatic t_regs;
		wr_reg(8'he4, 32'h1234_5678);
		wr_reg(8'hf6, 32'hffff_ffff);
		wr_reg(8'he6, 32'h0003_0001);
		rd_chk("rx div0", 8'he6, 32'h0003_0001);
		rd_chk("tx div0", 8'he4, 32'h1234_5678);
		rd_chk("unmapped", 8'h00, 32'h0000_0000);
		wr_reg(8'hf1, 32'hffff_ffff);
		rd_chk("ctl1 mask", 8'hf1, 32'h1fef_77ff);
		chk("ctl1 pins", 32'hf, {28'h0, dchn[1], d2d[1], lko[1].sclk_oe, lko[1].fs_oe});
		wr_reg(8'hf1, 32'h0000_0000);
		wr_reg(8'hf1, 32'h1f80_0000);
		rd_chk("multichannel", 8'hf1, 32'h1f80_0000);
		wr_reg(8'hf1, 32'h0000_0000);
	endtask

	task automatic rx_case(input logic [31:0] c, input logic [31:0] w,
		input logic [31:0] e, input int n);
		wr_reg(8'he1, 32'h0000_0000);
		u_peer.mode(c[16], !c[12]);
		wr_reg(8'he1, c);
		u_peer.send(w, n, c[17]);
		if (c[9])
			u_peer.send(w >> 16, n, c[17]);
		repeat (6) @(posedge clk);
		rd_chk("rx status", 8'he1, {3'b100, c[28:0]});
		chk("rx word", e, rxd[0]);
	endtask

	task automatic t_overflow;
		wr_reg(8'he1, 32'h0000_0000);
		u_peer.mode(1'b0, 1'b0);
		wr_reg(8'he1, 32'h000c_3071);
		for (int i = 1; i <= 3; i++)
			u_peer.send(32'h11 * i, 8, 1'b0);
		repeat (6) @(posedge clk);
		rd_chk("full", 8'he1, 32'he00c_3071);
		chk("dma", 32'h3, {30'h0, dreq[0], dchn[0]});
		chk("head", 32'h11, rxd[0]);
		@(posedge clk);
		pop <= 2'b01;
		@(posedge clk);
		pop <= 2'b00;
		rd_chk("popped", 8'he1, 32'ha00c_3071);
		chk("second", 32'h22, rxd[0]);
		wr_reg(8'he1, 32'h0000_0000);
		rd_chk("disabled", 8'he1, 32'h0000_0000);
		chk("dma off", 32'h0, {31'h0, dreq[0]});
	endtask

	task automatic t_loop;
		@(posedge clk);
		loop <= 2'b11;
		wr_reg(8'he1, 32'h0040_5471);
		for (int i = 0; i < 600 && rxd[0] !== 32'h0000_00ff; i++)
			@(posedge clk);
		chk("loopback", 32'h0000_00ff, rxd[0]);
		chk("int pins", 32'h3, {30'h0, lko[0].sclk_oe, lko[0].fs_oe});
		chk("rx1 idle", 32'h0000_0000, rxd[1]);
		wr_reg(8'he1, 32'h0000_0000);
	endtask

	task automatic final_report;
		if (bad_count == 0 && checks_done > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	initial begin
		repeat (5) @(posedge clk);
		chk("reset outs", 32'h0, {dreq, dchn, d2d, rvalid, rdata[24:0]});
		rstn <= 1'b1;
		rd_chk("ctl0 reset", 8'he1, 32'h0000_0000);
		rd_chk("ctl1 reset", 8'hf1, 32'h0000_0000);
		t_regs;
		rx_case(32'h0000_3071, 32'ha5, 32'h0000_00a5, 8);
		rx_case(32'h0000_3073, 32'ha5, 32'hffff_ffa5, 8);
		rx_case(32'h0000_3075, 32'hff, 32'h0000_0000, 8);
		rx_case(32'h0000_3077, 32'hd5, 32'h0000_0008, 8);
		rx_case(32'h0000_3079, 32'h01, 32'h0000_0080, 8);
		rx_case(32'h0002_3071, 32'h5a, 32'h0000_005a, 8);
		rx_case(32'h0001_3071, 32'h3c, 32'h0000_003c, 8);
		rx_case(32'h0000_2071, 32'h96, 32'h0000_0096, 8);
		rx_case(32'h0000_32f1, 32'habcd_1234, 32'habcd_1234, 16);
		rx_case(32'h0000_31f1, 32'h8000_0001, 32'h8000_0001, 32);
		t_overflow;
		t_loop;
		final_report;
	end

	initial begin
		#5_000_000;
		bad_count++;
		final_report;
	end
endmodule

bind srp_rx srp_rx_properties u_chk (.i_clk(i_clk), .i_rstn(i_rstn), .i_reg_wr(i_reg_wr),
	.i_reg_rd(i_reg_rd), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
	.o_reg_rdata(o_reg_rdata), .o_reg_rvalid(o_reg_rvalid), .o_link(o_link),
	.o_dma_req(o_dma_req), .o_dma_chain(o_dma_chain), .o_dma_2d(o_dma_2d));
